// file: verilog/core_exec.sv
// Purpose: Execution of 8-bit core instruction groups
// Assumes: Program memory answers prog_addr in the same cycle
// Notes:   Data space is held inside; dbg port reads it
// Function
// - Two-operand ops use accumulator plus memory/immediate
// - Clear and count ops reach all 256 bytes
// - Invert, rotate, shift act on accumulator only
// - Short branches test C set/clear, Z set/clear
// - Short branch span minus 15 to plus 16
// - Bit-test branch uses 8-bit signed displacement
// - Bit-test branches copy tested bit into carry
// - Bit set/clear any bit, flags kept
// - Stop acts as wait when watchdog selected
// - Long jump and call take 12-bit target
// - Immediate operand fetched after the opcode
// - ALU takes 4 cycles, flag effects per op
// - Short branch 1B/2cyc, bit-test 3B/5cyc
// - Bit set/clear two bytes, four cycles
// - Control ops 1B/2cyc except invert, rotate (1B/4cyc) and shift (2B/4cyc); of the rest only return_from_interrupt alters flags
// - Jump and call 2B/4cyc, flags kept
// - Target joins opcode nibble with next byte
// - Opcode bit 4 selects pointer register
// - Short opcode holds test, direction, span
// - Six-cell 12-bit return address stack
`timescale 1ns/1ps
`include "core_exec_defines.svh"
`default_nettype none

module core_exec (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    output logic      [11:0] prog_addr,
    input  wire logic [7:0]  prog_data,
    input  wire logic        watchdog_sel,
    input  wire logic        irq_pin,
    input  wire logic [7:0]  dbg_addr,
    output logic      [7:0]  dbg_data,
    output logic      [7:0]  acc_value,
    output logic             zero_flag,
    output logic             carry_flag,
    output logic      [11:0] instr_addr,
    output logic             instr_done,
    output logic             idle_mode,
    output logic             stop_mode
);

    typedef struct packed {
        core_exec_pkg::run_state_t st;
        logic [2:0]                cyc;
        logic [7:0]                op;
        logic [7:0]                b1;
        logic [7:0]                b2;
        logic [11:0]               pc;
        logic [11:0]               paddr;
        logic [7:0]                acc;
        logic                      z;
        logic                      c;
        logic                      sz;
        logic                      sc;
        logic                      isr;
        logic [2:0]                sp;
        logic [5:0][11:0]          stk;
        logic [255:0][7:0]         mem;
        logic [2:0]                wd_s;
        logic [2:0]                wk_s;
        logic                      wd;
        logic                      wk;
        logic                      done;
        logic [7:0]                dbg;
    } core_t;

    core_t s_ff;
    core_t nxt_s;

    // Decode of the held opcode
    logic [2:0]  cls;
    logic        is_short;
    logic        is_btest;
    logic        is_bmod;
    logic        is_ctl;
    logic [2:0]  last;
    logic [1:0]  len;
    logic [2:0]  alu;
    logic [3:0]  ctl;
    logic [7:0]  ea;
    logic [7:0]  opnd;
    logic        imm;
    logic        tbit;
    logic        cond;

    assign cls      = s_ff.op[2:0];
    assign is_short = ~cls[0];
    assign is_btest = (cls == `CLS_BIT) && !s_ff.op[`OP_MODE_BIT];
    assign is_bmod  = (cls == `CLS_BIT) && s_ff.op[`OP_MODE_BIT];
    assign is_ctl   = (cls == `CLS_INDIRECT) && s_ff.op[`OP_MODE_BIT];
    assign alu      = s_ff.op[7:5];
    assign ctl      = s_ff.op[7:4];
    assign imm      = (cls == `CLS_DIRECT) && s_ff.op[`OP_MODE_BIT]
                      && !alu[2];
    // Pointer picked by opcode bit, else direct address byte
    assign ea = (cls == `CLS_INDIRECT)
              ? (s_ff.op[`OP_PTR_BIT] ? s_ff.mem[`ADDR_PTR_Y]
                                      : s_ff.mem[`ADDR_PTR_X])
              : s_ff.b1;
    assign opnd = imm ? s_ff.b1 : s_ff.mem[ea];
    assign tbit = s_ff.mem[s_ff.b1][s_ff.op[7:5]];
    // Short branch test: nonzero, carry clear, zero, carry set
    assign cond = s_ff.op[2] ? (s_ff.op[1] ? s_ff.c : s_ff.z)
                             : (s_ff.op[1] ? !s_ff.c : !s_ff.z);

    // Length in bytes and final cycle index per instruction
    always_comb begin
        len  = 2'h1;
        last = `CYC_CTRL - 3'h1;
        if (is_short) begin
            last = `CYC_SHORT - 3'h1;
        end else if (cls == `CLS_EXT) begin
            len  = 2'h2;
            last = `CYC_EXT - 3'h1;
        end else if (is_btest) begin
            len  = 2'h3;
            last = `CYC_BITTEST - 3'h1;
        end else if (is_bmod) begin
            len  = 2'h2;
            last = `CYC_BITMOD - 3'h1;
        end else if (cls == `CLS_DIRECT) begin
            len  = 2'h2;
            last = `CYC_ALU - 3'h1;
        end else if (!is_ctl) begin
            last = `CYC_ALU - 3'h1;
        end else if (ctl == core_exec_pkg::CT_SLA) begin
            len  = 2'h2;
            last = `CYC_ALU - 3'h1;
        end else if (ctl == core_exec_pkg::CT_INV
                     || ctl == core_exec_pkg::CT_RLC) begin
            last = `CYC_ALU - 3'h1;
        end
    end

    // Next state of the whole core
    always_comb begin
        logic [8:0]  sum;
        logic [11:0] npc;
        logic [11:0] rpc;
        logic        taken;
        sum   = 9'h000;
        npc   = 12'h000;
        rpc   = 12'h000;
        taken = 1'b0;
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        nxt_s.dbg  = s_ff.mem[dbg_addr];
        // Pin filters: a change counts when stages two and three agree
        nxt_s.wd_s = {s_ff.wd_s[1:0], watchdog_sel};
        nxt_s.wk_s = {s_ff.wk_s[1:0], irq_pin};
        if (s_ff.wd_s[1] == s_ff.wd_s[2]) begin
            nxt_s.wd = s_ff.wd_s[2];
        end
        if (s_ff.wk_s[1] == s_ff.wk_s[2]) begin
            nxt_s.wk = s_ff.wk_s[2];
        end
        case (s_ff.st)
            core_exec_pkg::ST_IDLE, core_exec_pkg::ST_HALT: begin
                if (s_ff.wk) begin
                    nxt_s.st = core_exec_pkg::ST_RUN;
                end
            end
            core_exec_pkg::ST_RUN: begin
                if (s_ff.cyc == 3'h0) begin
                    if (s_ff.wk && !s_ff.isr) begin
                        // Interrupt entry at an instruction boundary
                        for (int i = 5; i > 0; i--) begin
                            nxt_s.stk[i] = s_ff.stk[i-1];
                        end
                        nxt_s.stk[0] = s_ff.pc;
                        if (s_ff.sp < `STACK_CELLS) begin
                            nxt_s.sp = s_ff.sp + 3'h1;
                        end
                        nxt_s.sz    = s_ff.z;
                        nxt_s.sc    = s_ff.c;
                        nxt_s.isr   = 1'b1;
                        nxt_s.pc    = `IRQ_VECTOR;
                        nxt_s.paddr = `IRQ_VECTOR;
                    end else begin
                        nxt_s.op    = prog_data;
                        nxt_s.cyc   = 3'h1;
                        nxt_s.paddr = s_ff.paddr + 12'h001;
                    end
                end else begin
                    // Operand bytes follow the opcode
                    if (s_ff.cyc == 3'h1) begin
                        nxt_s.b1 = prog_data;
                    end
                    if (s_ff.cyc == 3'h2) begin
                        nxt_s.b2 = prog_data;
                    end
                    nxt_s.cyc   = s_ff.cyc + 3'h1;
                    nxt_s.paddr = s_ff.paddr + 12'h001;
                    if (s_ff.cyc == last) begin
                        rpc = s_ff.pc + {10'h000, len};
                        npc = rpc;
                        if (is_short) begin
                            taken = cond;
                            if (s_ff.op[3]) begin
                                npc = s_ff.pc - {8'h00, s_ff.op[7:4]};
                            end else begin
                                npc = s_ff.pc + 12'h001
                                    + {8'h00, s_ff.op[7:4]};
                            end
                        end else if (cls == `CLS_EXT) begin
                            taken = 1'b1;
                            npc   = {s_ff.op[7:4], s_ff.b1};
                            if (!s_ff.op[3]) begin
                                for (int i = 5; i > 0; i--) begin
                                    nxt_s.stk[i] = s_ff.stk[i-1];
                                end
                                nxt_s.stk[0] = rpc;
                                if (s_ff.sp < `STACK_CELLS) begin
                                    nxt_s.sp = s_ff.sp + 3'h1;
                                end
                            end
                        end else if (is_btest) begin
                            nxt_s.c = tbit;
                            taken   = (tbit == s_ff.op[`OP_SENSE_BIT]);
                            npc = s_ff.pc + 12'h002
                                + {{4{s_ff.b2[7]}}, s_ff.b2};
                        end else if (is_bmod) begin
                            nxt_s.mem[s_ff.b1][s_ff.op[7:5]] =
                                s_ff.op[`OP_SENSE_BIT];
                        end else if (!is_ctl) begin
                            // Accumulator and data-space operations
                            case (alu)
                                core_exec_pkg::OP_ADD: begin
                                    sum = {1'b0, s_ff.acc} + {1'b0, opnd};
                                    nxt_s.acc = sum[7:0];
                                    nxt_s.c   = sum[8];
                                    nxt_s.z   = (sum[7:0] == 8'h00);
                                end
                                core_exec_pkg::OP_AND: begin
                                    nxt_s.acc = s_ff.acc & opnd;
                                    nxt_s.c   = 1'b0;
                                    nxt_s.z   = ((s_ff.acc & opnd) == 8'h00);
                                end
                                core_exec_pkg::OP_CMP,
                                core_exec_pkg::OP_SUB: begin
                                    sum = {1'b0, s_ff.acc} - {1'b0, opnd};
                                    nxt_s.c = sum[8];
                                    nxt_s.z = (sum[7:0] == 8'h00);
                                    if (alu[0]) begin
                                        nxt_s.acc = sum[7:0];
                                    end
                                end
                                core_exec_pkg::OP_INC,
                                core_exec_pkg::OP_DEC: begin
                                    sum = alu[0]
                                        ? {1'b0, opnd} - 9'h001
                                        : {1'b0, opnd} + 9'h001;
                                    nxt_s.mem[ea] = sum[7:0];
                                    nxt_s.z = (sum[7:0] == 8'h00);
                                end
                                core_exec_pkg::OP_CLR_MEM: begin
                                    nxt_s.mem[ea] = `RST_BYTE;
                                end
                                default: begin
                                    nxt_s.acc = `RST_ACC;
                                    nxt_s.z   = 1'b1;
                                    nxt_s.c   = 1'b0;
                                end
                            endcase
                        end else begin
                            case (ctl)
                                core_exec_pkg::CT_RET,
                                core_exec_pkg::CT_RETURN_FROM_INTERRUPT: begin
                                    taken = 1'b1;
                                    npc   = s_ff.stk[0];
                                    for (int i = 0; i < 5; i++) begin
                                        nxt_s.stk[i] = s_ff.stk[i+1];
                                    end
                                    if (s_ff.sp != 3'h0) begin
                                        nxt_s.sp = s_ff.sp - 3'h1;
                                    end
                                    if (ctl[1]) begin
                                        nxt_s.z   = s_ff.sz;
                                        nxt_s.c   = s_ff.sc;
                                        nxt_s.isr = 1'b0;
                                    end
                                end
                                core_exec_pkg::CT_STOP: begin
                                    nxt_s.st = s_ff.wd
                                        ? core_exec_pkg::ST_IDLE
                                        : core_exec_pkg::ST_HALT;
                                end
                                core_exec_pkg::CT_WAIT: begin
                                    nxt_s.st = core_exec_pkg::ST_IDLE;
                                end
                                core_exec_pkg::CT_INV: begin
                                    nxt_s.acc = ~s_ff.acc;
                                    nxt_s.c   = s_ff.acc[7];
                                    nxt_s.z   = (s_ff.acc == 8'hff);
                                end
                                core_exec_pkg::CT_RLC: begin
                                    nxt_s.acc = {s_ff.acc[6:0], s_ff.c};
                                    nxt_s.c   = s_ff.acc[7];
                                    nxt_s.z   = ({s_ff.acc[6:0], s_ff.c}
                                                 == 8'h00);
                                end
                                core_exec_pkg::CT_SLA: begin
                                    nxt_s.acc = {s_ff.acc[6:0], 1'b0};
                                    nxt_s.c   = s_ff.acc[7];
                                    nxt_s.z   = (s_ff.acc[6:0] == 7'h00);
                                end
                                default: begin
                                end
                            endcase
                        end
                        if (taken) begin
                            rpc = npc;
                        end
                        nxt_s.pc    = rpc;
                        nxt_s.paddr = rpc;
                        nxt_s.cyc   = 3'h0;
                        nxt_s.done  = 1'b1;
                    end
                end
            end
            default: begin
                nxt_s.st = core_exec_pkg::ST_RUN;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_ff       <= '0;
            s_ff.st    <= core_exec_pkg::ST_RUN;
            s_ff.pc    <= `RST_PC;
            s_ff.paddr <= `RST_PC;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from state
    assign prog_addr  = s_ff.paddr;
    assign dbg_data   = s_ff.dbg;
    assign acc_value  = s_ff.acc;
    assign zero_flag  = s_ff.z;
    assign carry_flag = s_ff.c;
    assign instr_addr = s_ff.pc;
    assign instr_done = s_ff.done;
    assign idle_mode  = (s_ff.st == core_exec_pkg::ST_IDLE);
    assign stop_mode  = (s_ff.st == core_exec_pkg::ST_HALT);

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_short_timing: assert property (
        (s_ff.st == core_exec_pkg::ST_RUN && s_ff.cyc == 3'h1 && is_short)
        |=> s_ff.done && s_ff.cyc == 3'h0 && $stable(s_ff.z)
            && $stable(s_ff.c))
        else $error("short branch length or flags wrong");
    a_alu_timing: assert property (
        (s_ff.st == core_exec_pkg::ST_RUN && s_ff.cyc == 3'h1
         && (cls == `CLS_DIRECT || (cls == `CLS_INDIRECT && !is_ctl)))
        |-> !s_ff.done [*3] ##1 s_ff.done)
        else $error("arithmetic op not four cycles");
    a_btest_timing: assert property (
        (s_ff.st == core_exec_pkg::ST_RUN && s_ff.cyc == 3'h1 && is_btest)
        |-> ##4 s_ff.done && $stable(s_ff.z))
        else $error("bit test branch not five cycles");
    a_btest_carry: assert property (
        (s_ff.done && is_btest) |-> s_ff.c == tbit)
        else $error("tested bit not in carry");
    a_bitmod_flags: assert property (
        (s_ff.done && is_bmod) |-> $stable(s_ff.z) && $stable(s_ff.c)
            && tbit == s_ff.op[`OP_SENSE_BIT])
        else $error("bit set or clear wrong");
    a_ext_target: assert property (
        (s_ff.done && cls == `CLS_EXT)
        |-> s_ff.pc == {s_ff.op[7:4], s_ff.b1})
        else $error("long target not formed from opcode and byte");
    a_stop_watchdog: assert property (
        (s_ff.done && is_ctl && ctl == core_exec_pkg::CT_STOP
         && $past(s_ff.wd)) |-> s_ff.st == core_exec_pkg::ST_IDLE)
        else $error("stop not replaced by wait");
    a_untaken_next: assert property (
        (s_ff.done && is_btest && tbit != s_ff.op[`OP_SENSE_BIT])
        |-> s_ff.pc == $past(s_ff.pc) + 12'h003)
        else $error("untaken bit test not skipped fully");
    a_stack_bound: assert property (
        s_ff.sp <= `STACK_CELLS)
        else $error("stack depth above six");

endmodule : core_exec

`default_nettype wire

// file: verilog/core_exec_defines.svh
// Purpose: Constants for the 8-bit core execution block
// Assumes: One clock, opcode layout as decoded in core_exec
// Notes:   Cycle counts are whole instruction lengths
`ifndef CORE_EXEC_DEFINES_SVH
`define CORE_EXEC_DEFINES_SVH

// Instruction lengths in clock cycles
`define CYC_ALU      3'h4
`define CYC_SHORT    3'h2
`define CYC_BITTEST  3'h5
`define CYC_BITMOD   3'h4
`define CYC_CTRL     3'h2
`define CYC_EXT      3'h4

// Opcode class field, low three bits
`define CLS_EXT      3'h1
`define CLS_BIT      3'h3
`define CLS_DIRECT   3'h5
`define CLS_INDIRECT 3'h7

// Opcode field positions
`define OP_MODE_BIT  3
`define OP_PTR_BIT   4
`define OP_SENSE_BIT 4

// Pointer registers in the data space
`define ADDR_PTR_X   8'h80
`define ADDR_PTR_Y   8'h81

// Interrupt entry address and stack depth
`define IRQ_VECTOR   12'hff0
`define STACK_CELLS  3'h6

// Reset values
`define RST_PC       12'h000
`define RST_BYTE     8'h00
`define RST_ACC      8'h00

`endif

// file: verilog/core_exec_pkg.sv
// Purpose: Types for the 8-bit core execution block
// Assumes: Constants come from core_exec_defines.svh
// Notes:   None
`default_nettype none
package core_exec_pkg;

    // Core activity states, one-hot
    typedef enum logic [2:0] {
        ST_RUN  = 3'h1,
        ST_IDLE = 3'h2,
        ST_HALT = 3'h4
    } run_state_t;

    // Two-operand and data-space operation select
    typedef enum logic [2:0] {
        OP_ADD     = 3'h0,
        OP_AND     = 3'h1,
        OP_CMP     = 3'h2,
        OP_SUB     = 3'h3,
        OP_INC     = 3'h4,
        OP_DEC     = 3'h5,
        OP_CLR_MEM = 3'h6,
        OP_CLR_ACC = 3'h7
    } alu_sel_t;

    // Inherent group select, opcode bits 7..4
    typedef enum logic [3:0] {
        CT_NOP  = 4'h0,
        CT_RET  = 4'h1,
        CT_RETURN_FROM_INTERRUPT = 4'h2,
        CT_STOP = 4'h3,
        CT_WAIT = 4'h4,
        CT_INV  = 4'h5,
        CT_RLC  = 4'h6,
        CT_SLA  = 4'h7
    } ctl_sel_t;

endpackage : core_exec_pkg

`default_nettype wire

// file: tb/mcu_core_instruction_execution_tb.sv
// Purpose: Self-checking bench for the core execution block
// Assumes: Program memory modelled as a combinational table
// Notes:   Each scenario reloads memory and resets the core
`timescale 1ns/1ps
`default_nettype none

module mcu_core_instruction_execution_tb;

    logic        ref_clk;
    logic        reset;
    logic [11:0] prog_addr;
    logic [7:0]  prog_data;
    logic        watchdog_sel;
    logic        irq_pin;
    logic [7:0]  dbg_addr;
    logic [7:0]  dbg_data;
    logic [7:0]  acc_value;
    logic        zero_flag;
    logic        carry_flag;
    logic [11:0] instr_addr;
    logic        instr_done;
    logic        idle_mode;
    logic        stop_mode;
    logic [7:0]  rom [0:4095];
    int          err_count;
    int          n_checks;
    int          lag;

    core_exec u_dut (
        .ref_clk      (ref_clk),
        .reset        (reset),
        .prog_addr    (prog_addr),
        .prog_data    (prog_data),
        .watchdog_sel (watchdog_sel),
        .irq_pin      (irq_pin),
        .dbg_addr     (dbg_addr),
        .dbg_data     (dbg_data),
        .acc_value    (acc_value),
        .zero_flag    (zero_flag),
        .carry_flag   (carry_flag),
        .instr_addr   (instr_addr),
        .instr_done   (instr_done),
        .idle_mode    (idle_mode),
        .stop_mode    (stop_mode)
    );

    // Program memory answers in the same cycle
    assign prog_data = rom[prog_addr];

    // Clock and time-zero input values
    initial begin
        ref_clk = 1'b0;
        reset = 1'b1;
        watchdog_sel = 1'b0;
        irq_pin = 1'b0;
        dbg_addr = 8'hff;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Hold the core in reset and fill memory with no-ops
    task automatic rst(input logic wdg);
        @(posedge ref_clk);
        reset <= 1'b1;
        watchdog_sel <= wdg;
        for (int i = 0; i < 4096; i++) rom[i] = 8'h0f;
    endtask : rst

    task automatic rel;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
    endtask : rel

    task automatic prog(input int a, input logic [7:0] b0, b1, b2);
        rom[a] = b0;
        rom[a + 1] = b1;
        rom[a + 2] = b2;
    endtask : prog

    // Wait for completion, check spacing and next address
    task automatic step(input int n, input logic [11:0] pc);
        int c;
        c = lag;
        lag = 0;
        do begin
            @(negedge ref_clk);
            c++;
        end while (instr_done !== 1'b1 && c < 60);
        chk({11'h000, instr_done}, 12'h001);
        if (n != 0) chk(12'(c), 12'(n));
        chk(instr_addr, pc);
    endtask : step

    // Data-space view lags the write by one cycle
    task automatic peek(input logic [9:0] exp);
        @(negedge ref_clk);
        lag = 1;
        chk({2'b00, dbg_data, zero_flag, carry_flag}, {2'b00, exp});
    endtask : peek

    // Accumulator group: immediate add and compare, then rotate and invert
    task automatic s_alu;
        rst(1'b0);
        prog(1, 8'h0d, 8'h05, 8'h0d);
        prog(4, 8'hfb, 8'h4d, 8'h01);
        prog(7, 8'h6f, 8'h5f, 8'h0f);
        rel();
        step(0, 12'h001);
        step(4, 12'h003);
        chk({acc_value, zero_flag, carry_flag}, {8'h05, 2'b00});
        step(4, 12'h005);
        chk({acc_value, zero_flag, carry_flag}, {8'h00, 2'b11});
        step(4, 12'h007);
        chk({acc_value, zero_flag, carry_flag}, {8'h00, 2'b01});
        step(4, 12'h008);
        chk({acc_value, zero_flag, carry_flag}, {8'h01, 2'b00});
        step(4, 12'h009);
        chk({acc_value, zero_flag, carry_flag}, {8'hfe, 2'b00});
    endtask : s_alu

    // Data-space counts, bit modify and bit-test branches
    task automatic s_mem;
        rst(1'b0);
        prog(1, 8'h85, 8'hff, 8'ha5);
        prog(4, 8'hff, 8'hfb, 8'hff);
        prog(7, 8'hf3, 8'hff, 8'h10);
        prog(12'h019, 8'he3, 8'hff, 8'h80);
        prog(12'h01c, 8'heb, 8'hff, 8'h0f);
        rel();
        step(0, 12'h001);
        step(4, 12'h003);
        peek({8'h01, 2'b00});
        step(4, 12'h005);
        peek({8'h00, 2'b10});
        step(4, 12'h007);
        peek({8'h80, 2'b10});
        step(5, 12'h019);
        chk({zero_flag, carry_flag}, 2'b11);
        step(5, 12'h01c);
        chk({zero_flag, carry_flag}, 2'b11);
        step(4, 12'h01e);
        peek({8'h00, 2'b11});
    endtask : s_mem

    // Short branches, jump, call, return and stop
    task automatic s_flow(input logic wdg);
        rst(wdg);
        prog(1, 8'h34, 8'hf0, 8'ha9);
        rom[4] = 8'h34;
        rom[12'h012] = 8'hfa;
        prog(12'ha34, 8'h11, 8'h00, 8'h3f);
        rom[12'h100] = 8'h1f;
        rom[12'ha36] = 8'h3f;
        // Handler sets Z; its return must restore the saved flags
        rom[12'hff0] = 8'h0d;
        rom[12'hff1] = 8'h00;
        rom[12'hff2] = 8'h2f;
        rel();
        step(0, 12'h001);
        step(2, 12'h002);
        step(2, 12'h012);
        step(2, 12'h003);
        step(4, 12'ha34);
        step(4, 12'h100);
        step(2, 12'ha36);
        step(2, 12'ha37);
        repeat (2) @(negedge ref_clk);
        chk({idle_mode, stop_mode}, wdg ? 2'b10 : 2'b01);
        chk({zero_flag, carry_flag}, 2'b00);
        // Pin held four cycles: long enough to wake, short of re-entry
        @(posedge ref_clk);
        irq_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        irq_pin <= 1'b0;
        step(0, 12'hff2);
        chk({idle_mode, stop_mode, zero_flag, carry_flag}, 4'b0010);
        step(2, 12'ha37);
        chk({zero_flag, carry_flag}, 2'b00);
    endtask : s_flow

    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    // Main sequence
    initial begin
        err_count = 0;
        n_checks = 0;
        s_alu();
        s_mem();
        s_flow(1'b1);
        s_flow(1'b0);
        complete_run();
    end

    // Watchdog against a hung core
    initial begin
        #20000;
        err_count++;
        complete_run();
    end

endmodule : mcu_core_instruction_execution_tb

`default_nettype wire
